// [hdl/lpcc_dev.sv]
module lpcc_dev
(
	input wire logic clk,
	input wire logic rst,
	lpcc_if.dev bus,
	input wire logic sleep_stop_instr,
	input wire logic [15:0] stop_operand,
	output logic stop_busy,
	output logic low_freq_mode,
	output logic wake_event,
	output logic [2:0] sr_mask
);
	import lpcc_pkg::*;

	// All state is flip-flops with no dynamic storage, so a stalled clock loses nothing.
	lpcc_state_t st_r, st_nxt;
	logic ts_r, ts_nxt;
	logic [15:0] data_r, data_nxt;
	logic [3:0] pst_r, pst_nxt;
	logic cdo_r, cdo_nxt;
	logic lost_r, lost_nxt;
	logic lfo_r, lfo_nxt;
	logic wake_r, wake_nxt;
	logic [2:0] mask_r, mask_nxt;
	logic [3:0] lock_r, lock_nxt;
	logic rst_in;

	assign rst_in = rst | bus.reset_input;

	always_comb
	begin
		st_nxt = st_r;
		ts_nxt = 1'b0;
		data_nxt = data_r;
		pst_nxt = pst_r;
		cdo_nxt = cdo_r;
		lost_nxt = lost_r;
		lfo_nxt = lfo_r;
		wake_nxt = 1'b0;
		mask_nxt = mask_r;
		lock_nxt = lock_r;
		case (st_r)
			ST_RUN:
			begin
				if (sleep_stop_instr)
				begin
					st_nxt = ST_BCAST;
					ts_nxt = 1'b1;
					data_nxt = stop_operand;
				end
			end
			ST_BCAST:
			begin
				// Cycle ends on either acknowledge
				if (bus.transfer_ack || bus.transfer_error_ack)
				begin
					st_nxt = ST_STOP;
					mask_nxt = data_r[10:8];
					pst_nxt = PST_STOP;
					cdo_nxt = 1'b1;
				end
			end
			ST_STOP:
			begin
				lfo_nxt = bus.low_freq_select;
				// Level 7 is non-maskable
				if (bus.irq_priority_level > mask_r || bus.irq_priority_level == 3'h7)
				begin
					st_nxt = ST_WAKE;
					cdo_nxt = 1'b0;
					lock_nxt = LOCK_CYCLES;
				end
			end
			ST_WAKE:
			begin
				if (lock_r == 4'h1)
				begin
					st_nxt = ST_RUN;
					pst_nxt = PST_NORMAL;
					wake_nxt = 1'b1;
				end
				lock_nxt = lock_r - 4'h1;
			end
			default:
				st_nxt = ST_RUN;
		endcase
		// Clock faults only count while clocking normally, broadcast included
		if ((st_r == ST_RUN || st_r == ST_BCAST) && !lfo_r && bus.clk_fault)
			lost_nxt = 1'b1;
		if (rst_in)
		begin
			st_nxt = ST_RUN;
			ts_nxt = 1'b0;
			pst_nxt = PST_NORMAL;
			cdo_nxt = 1'b0;
			lost_nxt = 1'b0;
			lfo_nxt = bus.low_freq_select;
			mask_nxt = MASK_RST;
			lock_nxt = 4'h0;
			data_nxt = 16'h0000;
		end
	end

	always_ff @(posedge clk)
	begin
		st_r <= st_nxt;
		ts_r <= ts_nxt;
		data_r <= data_nxt;
		pst_r <= pst_nxt;
		cdo_r <= cdo_nxt;
		lost_r <= lost_nxt;
		lfo_r <= lfo_nxt;
		wake_r <= wake_nxt;
		mask_r <= mask_nxt;
		lock_r <= lock_nxt;
	end

	logic oe_r, oe_nxt;
	logic bact_r, bact_nxt;
	always_comb
	begin
		// Output floats in reset, stop and low-frequency operation
		oe_nxt = !rst_in && (st_nxt == ST_RUN || st_nxt == ST_BCAST) && !lfo_nxt;
		bact_nxt = (st_nxt == ST_BCAST) && !rst_in;
	end
	always_ff @(posedge clk)
	begin
		oe_r <= oe_nxt;
		bact_r <= bact_nxt;
	end

	// Broadcast attributes are constant while the cycle is open
	assign bus.addr = bact_r ? STOP_ADDR : 32'h00000000;
	assign bus.wr = bact_r;
	assign bus.transfer_type = bact_r ? STOP_TT : 2'h0;
	assign bus.transfer_modifier = STOP_TM;
	assign bus.transfer_size = bact_r ? STOP_SIZE : 2'h0;
	assign bus.data = data_r;
	assign bus.ts = ts_r;
	assign bus.proc_status_code = pst_r;
	assign bus.clock_disable_ok = cdo_r;
	assign bus.clk_lost_o = lost_r;
	assign bus.clk_lost_oe = oe_r;
	assign stop_busy = bact_r;
	assign low_freq_mode = lfo_r;
	assign wake_event = wake_r;
	assign sr_mask = mask_r;
endmodule

// [hdl/lpcc_if.sv]
interface lpcc_if;
	logic [31:0] addr;
	logic wr;
	logic [1:0] transfer_type;
	logic [2:0] transfer_modifier;
	logic [1:0] transfer_size;
	logic [15:0] data;
	logic ts;
	logic transfer_ack;
	logic transfer_error_ack;
	logic [3:0] proc_status_code;
	logic clock_disable_ok;
	logic clk_lost_o;
	logic clk_lost_oe;
	logic low_freq_select;
	logic [2:0] irq_priority_level;
	logic reset_input;
	logic clk_fault;
	logic clk_lost_flag;
	assign clk_lost_flag = clk_lost_oe ? clk_lost_o : 1'b0;
	modport dev(output addr, wr, transfer_type, transfer_modifier, transfer_size, data, ts,
		proc_status_code, clock_disable_ok, clk_lost_o, clk_lost_oe,
		input transfer_ack, transfer_error_ack, low_freq_select, irq_priority_level,
		reset_input, clk_fault);
	modport sys(input addr, wr, transfer_type, transfer_modifier, transfer_size, data, ts,
		proc_status_code, clock_disable_ok, clk_lost_flag,
		output transfer_ack, transfer_error_ack, low_freq_select, irq_priority_level,
		reset_input, clk_fault);
endinterface

// [hdl/lpcc_pkg.sv]
package lpcc_pkg;
	localparam logic [31:0] STOP_ADDR = 32'hfffffffe;
	localparam logic [1:0] STOP_TT = 2'h3;
	localparam logic [2:0] STOP_TM = 3'h0;
	localparam logic [1:0] STOP_SIZE = 2'h2;
	localparam logic [3:0] PST_NORMAL = 4'h0;
	localparam logic [3:0] PST_STOP = 4'h6;
	localparam logic [2:0] MASK_RST = 3'h7;
	localparam logic [3:0] LOCK_CYCLES = 4'h8;
	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_BCAST = 2'b01,
		ST_STOP = 2'b10,
		ST_WAKE = 2'b11
	} lpcc_state_t;
endpackage

// [hdl/lpcc_sys.sv]
module lpcc_sys
(
	input wire logic clk,
	input wire logic rst,
	lpcc_if.sys bus,
	input wire logic ack_enable,
	input wire logic ack_error,
	input wire logic low_freq_req,
	input wire logic [2:0] irq_req,
	input wire logic clk_fault_in,
	output logic bclk_gate_ok,
	output logic stop_seen,
	output logic reset_pending
);
	import lpcc_pkg::*;

	logic pend_r, pend_nxt;
	logic ta_r, ta_nxt;
	logic tea_r, tea_nxt;
	logic reset_input_r, reset_input_nxt;
	logic gate_r, gate_nxt;
	logic seen_r, seen_nxt;
	logic hit;

	assign hit = bus.ts && bus.wr && bus.addr == STOP_ADDR && bus.transfer_type == STOP_TT
		&& bus.transfer_modifier == STOP_TM && bus.transfer_size == STOP_SIZE;

	always_comb
	begin
		pend_nxt = pend_r | hit;
		ta_nxt = 1'b0;
		tea_nxt = 1'b0;
		// Withholding acknowledge delays stop entry
		if (pend_r && ack_enable)
		begin
			pend_nxt = 1'b0;
			ta_nxt = !ack_error;
			tea_nxt = ack_error;
		end
		seen_nxt = bus.proc_status_code == PST_STOP;
		// Clock may be gated only while permitted; stable otherwise
		gate_nxt = bus.clock_disable_ok && seen_nxt;
		// Reset the device after a lost clock
		reset_input_nxt = bus.clk_lost_flag;
		if (rst)
		begin
			pend_nxt = 1'b0;
			ta_nxt = 1'b0;
			tea_nxt = 1'b0;
			seen_nxt = 1'b0;
			gate_nxt = 1'b0;
			reset_input_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		pend_r <= pend_nxt;
		ta_r <= ta_nxt;
		tea_r <= tea_nxt;
		reset_input_r <= reset_input_nxt;
		gate_r <= gate_nxt;
		seen_r <= seen_nxt;
	end

	assign bus.transfer_ack = ta_r;
	assign bus.transfer_error_ack = tea_r;
	assign bus.reset_input = reset_input_r;
	assign bus.low_freq_select = low_freq_req;
	assign bus.irq_priority_level = irq_req;
	assign bus.clk_fault = clk_fault_in;
	assign bclk_gate_ok = gate_r;
	assign stop_seen = seen_r;
	assign reset_pending = reset_input_r;
endmodule

// [tb/low_power_clock_control_tb.sv]
module low_power_clock_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lpcc_pkg::*;
	logic clk, rst, instr, busy, lfm, ack_en, ack_err, lf_req, fault;
	logic wake, gate, seen, rpend;
	logic [15:0] operand;
	logic [2:0] mask, irq;
	int fail_count = 0;
	int num_checks = 0;
	lpcc_if bus();
	lpcc_dev lpcc_dev_inst (.clk(clk), .rst(rst), .bus(bus), .sleep_stop_instr(instr),
		.stop_operand(operand), .stop_busy(busy), .low_freq_mode(lfm), .wake_event(wake),
		.sr_mask(mask));
	lpcc_sys lpcc_sys_inst (.clk(clk), .rst(rst), .bus(bus), .ack_enable(ack_en),
		.ack_error(ack_err), .low_freq_req(lf_req), .irq_req(irq), .clk_fault_in(fault),
		.bclk_gate_ok(gate), .stop_seen(seen), .reset_pending(rpend));
	lpcc_chk lpcc_chk_inst (.clk(clk), .rst(rst), .ts(bus.ts), .addr(bus.addr),
		.transfer_type(bus.transfer_type), .transfer_ack(bus.transfer_ack),
		.proc_status_code(bus.proc_status_code), .clock_disable_ok(bus.clock_disable_ok),
		.clk_lost_o(bus.clk_lost_o), .clk_lost_oe(bus.clk_lost_oe),
		.reset_input(bus.reset_input), .irq_priority_level(bus.irq_priority_level));
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Bounded wait on the stop handshake (k=0) or the loss flag (k=1)
	task automatic wt(bit k, logic v);
		int i;
		for (i = 0; i < 40 && (k ? bus.clk_lost_flag : bus.clock_disable_ok) !== v; i++)
			cyc(1);
		if (i == 40)
		begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task automatic go_stop(logic [2:0] m);
		operand = {5'h00, m, 8'h00};
		instr = 1'h1;
		cyc(1);
		instr = 1'h0;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		{rst, instr, ack_en, ack_err, lf_req, fault} = 6'h20;
		operand = 16'h0000;
		irq = 3'h0;
		cyc(10);
		rst = 1'h0;
		cyc(3);
		lf_req = 1'h1;
		cyc(4);
		chk("lf run", 0, lfm);
		lf_req = 1'h0;
		go_stop(3'h3);
		cyc(6);
		chk("busy", 1, busy);
		chk("cdo early", 0, bus.clock_disable_ok);
		ack_en = 1'h1;
		wt(0, 1'h1);
		chk("pst", PST_STOP, bus.proc_status_code);
		chk("mask", 3, mask);
		chk("oe stop", 0, bus.clk_lost_oe);
		irq = 3'h3;
		lf_req = 1'h1;
		cyc(6);
		chk("cdo irq", 1, bus.clock_disable_ok);
		chk("gate", 1, gate);
		chk("seen", 1, seen);
		chk("lf stop", 1, lfm);
		irq = 3'h4;
		wt(0, 1'h0);
		cyc(7);
		chk("wake early", 0, wake);
		cyc(1);
		chk("wake", 1, wake);
		chk("gate off", 0, gate);
		cyc(1);
		chk("wake once", 0, wake);
		chk("pst run", PST_NORMAL, bus.proc_status_code);
		fault = 1'h1;
		cyc(4);
		chk("flag lf", 0, bus.clk_lost_flag);
		{fault, irq, lf_req, ack_err} = 6'h01;
		go_stop(3'h7);
		wt(0, 1'h1);
		cyc(2);
		chk("lf off", 0, lfm);
		irq = 3'h7;
		wt(0, 1'h0);
		cyc(10);
		fault = 1'h1;
		wt(1, 1'h1);
		cyc(1);
		chk("rst pend", 1, rpend);
		fault = 1'h0;
		wt(1, 1'h0);
		cyc(3);
		chk("pst rst", PST_NORMAL, bus.proc_status_code);
		report_and_stop();
	end
endmodule

// [tb/lpcc_chk.sv]
module lpcc_chk
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ts,
	input wire logic [31:0] addr,
	input wire logic [1:0] transfer_type,
	input wire logic transfer_ack,
	input wire logic [3:0] proc_status_code,
	input wire logic clock_disable_ok,
	input wire logic clk_lost_o,
	input wire logic clk_lost_oe,
	input wire logic reset_input,
	input wire logic [2:0] irq_priority_level
);
	timeunit 1ns;
	timeprecision 1ns;
	import lpcc_pkg::*;
	wire cdo = clock_disable_ok;
	wire [3:0] pst = proc_status_code;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst || reset_input);
	sequence s_relock;
		(pst == PST_STOP) [*8] ##1 pst == PST_NORMAL;
	endsequence
	chk_bcast_attrs:
	assert property (ts |-> addr == STOP_ADDR && transfer_type == STOP_TT) else $error("bad bcast");
	chk_stop_entry:
	assert property (transfer_ack |=> cdo && pst == PST_STOP) else $error("no stop");
	chk_cdo_code:
	assert property (cdo |-> pst == PST_STOP) else $error("bad code");
	chk_wake_top:
	assert property (cdo && irq_priority_level == 3'h7 |=> !cdo) else $error("no wake");
	chk_stay_low:
	assert property (cdo && irq_priority_level == 3'h0 |=> cdo) else $error("woke");
	chk_relock_time:
	assert property ($fell(cdo) |-> s_relock) else $error("bad relock");
	chk_float_stop:
	assert property (pst == PST_STOP |-> !clk_lost_oe) else $error("flag driven");
	chk_lost_hold:
	assert property (clk_lost_oe && clk_lost_o |=> clk_lost_oe && clk_lost_o) else $error("drop");
endmodule
